// >>> hw/icst_defines.vh
// Constants for the input capture block: register offsets, field
// positions, reset values and encodings.
// Assumes it is included by bare name from the design files.
`ifndef ICST_DEFINES_VH
`define ICST_DEFINES_VH

// ***********************************************
// Sizes
// ***********************************************
`define ICST_NUM_CH 5
`define ICST_CNT_W 16
`define ICST_FIFO_D 4
`define ICST_CNT_BITS 3
`define ICST_NUM_CLK 6
`define ICST_NUM_SYNC 20

// ***********************************************
// Register map (byte offsets)
// ***********************************************
`define ICST_OFS_CON1 4'h0
`define ICST_OFS_CON2 4'h4
`define ICST_OFS_BUF 4'h8
`define ICST_OFS_STAT 4'hC
`define ICST_OFS_IRQ_STAT 8'h80
`define ICST_OFS_IRQ_MASK 8'h84

// ***********************************************
// Field positions
// ***********************************************
`define ICST_C1_MODE_HI 1
`define ICST_C1_MODE_LO 0
`define ICST_C1_CSEL_HI 4
`define ICST_C1_CSEL_LO 2
`define ICST_C1_CASC 8
`define ICST_C1_W 9
`define ICST_C2_SEL_HI 4
`define ICST_C2_SEL_LO 0
`define ICST_C2_TSTAT 6
`define ICST_C2_TMODE 7
`define ICST_C2_W 8
`define ICST_ST_RUN 8
`define ICST_IRQ_OVF_LSB 5
`define ICST_IRQ_W 10

// ***********************************************
// Reset values and encodings
// ***********************************************
`define ICST_C1_RST 9'h000
`define ICST_C2_RST 8'h00
`define ICST_IRQ_RST 10'h000
`define ICST_EDGE_OFF 2'h0
`define ICST_EDGE_RISE 2'h1
`define ICST_EDGE_FALL 2'h2
`define ICST_EDGE_BOTH 2'h3
`define ICST_SEL_NONE 5'h00

`endif

// >>> hw/icst_fifo.v
// Capture FIFO: flip-flop storage addressed by read and write index.
// Assumes one clock, synchronous active-high reset; a push into a full
// FIFO with no pop is dropped and stored values stay.
`timescale 1ns/100ps
`default_nettype none

module icst_fifo #(
	parameter W = 16,
	parameter D = 4,
	parameter PW = 2,
	parameter CW = 3
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire push_in,
	input wire pop_in,
	input wire [W-1:0] data_in,
	output wire [W-1:0] data_out,
	output wire [CW-1:0] count_out,
	output wire full_out
);

	localparam [31:0] LAST_I = D - 1;
	localparam [31:0] FULL_I = D;
	localparam [PW-1:0] LAST = LAST_I[PW-1:0];
	localparam [CW-1:0] FULL_CNT = FULL_I[CW-1:0];

	reg [W-1:0] mem_q [0:D-1];
	reg [PW-1:0] rd_q;
	reg [PW-1:0] wr_q;
	reg [CW-1:0] cnt_q;

	wire do_pop = pop_in & (cnt_q != {CW{1'b0}});
	// Full plus pop frees a slot in the same cycle
	wire do_push = push_in & ((cnt_q != FULL_CNT) | do_pop);

	assign data_out = mem_q[rd_q];
	assign count_out = cnt_q;
	assign full_out = (cnt_q == FULL_CNT);

	always @(posedge clk_in)
	begin
		if (do_push)
			mem_q[wr_q] <= data_in;
	end

	always @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			rd_q <= {PW{1'b0}};
			wr_q <= {PW{1'b0}};
			cnt_q <= {CW{1'b0}};
		end
		else
		begin
			if (do_push)
				wr_q <= (wr_q == LAST) ? {PW{1'b0}} : wr_q + 1'b1;
			if (do_pop)
				rd_q <= (rd_q == LAST) ? {PW{1'b0}} : rd_q + 1'b1;
			if (do_push & ~do_pop)
				cnt_q <= cnt_q + 1'b1;
			else if (do_pop & ~do_push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule // icst_fifo

`default_nettype wire

// >>> hw/icst_top.v
// Input capture block with dedicated counters, AHB-Lite register slave.
// Assumes one 40 MHz clock; pins, clock ticks and sync events are
// synchronous one-cycle or level inputs on that clock.
//
// How it works
// R1 - Five independent capture channels, own interrupts
// R2 - Odd channel cascades onto lower for 32 bits
// R3 - Four-deep FIFO holds captures per channel
// R4 - Private 16-bit counter, six selectable clocks
// R5 - Free-running counter wraps from all-ones to zero
// R6 - Capture pushes present counter value into FIFO
// R7 - Sync mode captures once clock source selected
// R8 - Sync mode source event clears counter
// R9 - Trigger mode holds counter until source event
// R10 - Zero select, trigger bit clear: free-running
// R11 - Nonzero select picks source, sync or trigger
// R12 - Trigger bit set trigger, clear sync
// R13 - Zero select with trigger bit: software trigger
// R14 - Software sets trigger status to start
// R15 - Twenty selectable internal source events
// R16 - Full FIFO keeps data, raises overflow flag
`timescale 1ns/100ps
`default_nettype none
`include "icst_defines.vh"

module icst_top #(
	parameter NCH = `ICST_NUM_CH,
	parameter CW = `ICST_CNT_W,
	parameter FD = `ICST_FIFO_D
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output reg [31:0] hrdata_out,
	output reg hreadyout_out,
	output reg hresp_out,
	input wire [NCH-1:0] capture_input_pin_in,
	input wire [`ICST_NUM_SYNC-1:0] sync_event_in,
	input wire [`ICST_NUM_CLK-1:0] clk_src_tick_in,
	output reg irq_out
);

	// ***********************************************
	// Mode decode codes
	// ***********************************************
	localparam [3:0] M_FREE = 4'h1;
	localparam [3:0] M_SYNC = 4'h2;
	localparam [3:0] M_TRIG = 4'h4;
	localparam [3:0] M_SWT = 4'h8;
	localparam [31:0] NCLK_I = `ICST_NUM_CLK;
	localparam [31:0] NSYNC_I = `ICST_NUM_SYNC;
	localparam [31:0] NCH_I = NCH;
	localparam [2:0] NCLK = NCLK_I[2:0];
	localparam [4:0] NSYNC = NSYNC_I[4:0];
	localparam [2:0] NCH3 = NCH_I[2:0];

	// ***********************************************
	// AHB-Lite slave
	// ***********************************************
	wire addr_ok = hsel_in & hready_in & htrans_in[1];
	wire rd_acc = addr_ok & ~hwrite_in;
	wire [2:0] rd_ch = haddr_in[6:4];
	wire [3:0] rd_reg = haddr_in[3:0];
	wire rd_hi0 = (haddr_in[31:8] == 24'h000000);
	wire rd_chan = rd_hi0 & ~haddr_in[7] & (rd_ch < NCH3);
	wire [6:0] rd_base = {rd_ch, 4'h0};

	reg wr_pend_q;
	reg [7:0] wr_addr_q;
	wire [2:0] wr_ch = wr_addr_q[6:4];
	wire [3:0] wr_reg = wr_addr_q[3:0];
	wire wr_chan = wr_pend_q & ~wr_addr_q[7];
	wire wr_irq_stat = wr_pend_q & (wr_addr_q == `ICST_OFS_IRQ_STAT);
	wire wr_irq_mask = wr_pend_q & (wr_addr_q == `ICST_OFS_IRQ_MASK);

	// Flattened per-channel views for the read mux
	wire [NCH*16-1:0] c1_all;
	wire [NCH*16-1:0] c2_all;
	wire [NCH*16-1:0] data_all;
	wire [NCH*16-1:0] st_all;
	wire [NCH-1:0] push_w;
	wire [NCH-1:0] ovf_w;

	reg [`ICST_IRQ_W-1:0] stat_q;
	reg [`ICST_IRQ_W-1:0] mask_q;
	reg [31:0] rd_data;

	always @*
	begin
		rd_data = 32'h00000000;
		if (rd_chan)
		begin
			case (rd_reg)
			`ICST_OFS_CON1: rd_data = {16'h0000, c1_all[rd_base +: 16]};
			`ICST_OFS_CON2: rd_data = {16'h0000, c2_all[rd_base +: 16]};
			`ICST_OFS_BUF: rd_data = {16'h0000, data_all[rd_base +: 16]};
			`ICST_OFS_STAT: rd_data = {16'h0000, st_all[rd_base +: 16]};
			default: rd_data = 32'h00000000;
			endcase
		end
		else if (rd_hi0 & (haddr_in[7:0] == `ICST_OFS_IRQ_STAT))
			rd_data = {22'h000000, stat_q};
		else if (rd_hi0 & (haddr_in[7:0] == `ICST_OFS_IRQ_MASK))
			rd_data = {22'h000000, mask_q};
	end

	// Zero wait states: read data is sampled in the address phase
	always @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_out <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
		else
		begin
			wr_pend_q <= addr_ok & hwrite_in & rd_hi0;
			if (addr_ok)
				wr_addr_q <= haddr_in[7:0];
			if (rd_acc)
				hrdata_out <= rd_data;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	// ***********************************************
	// Capture channels
	// ***********************************************
	wire [NCH-1:0] tick_eff;
	wire [NCH-1:0] clr_eff;
	wire [NCH-1:0] run_eff;
	wire [NCH-1:0] own_edge;
	wire [NCH-1:0] own_clr;
	wire [NCH-1:0] own_run;
	wire [NCH-1:0] own_tick;
	wire [NCH-1:0] own_ok;
	wire [NCH-1:0] carry_w;

	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1)
		begin : g_ch // [R1]
			localparam [31:0] IDX_I = i;
			localparam [2:0] IDX = IDX_I[2:0];
			reg [`ICST_C1_W-1:0] c1_q;
			reg [`ICST_C2_W-1:0] c2_q;
			reg [CW-1:0] cnt_q;
			reg pin_q;
			reg run;
			wire [4:0] sel = c2_q[`ICST_C2_SEL_HI:`ICST_C2_SEL_LO];
			wire tm = c2_q[`ICST_C2_TMODE];
			wire sel_nz = (sel != `ICST_SEL_NONE);
			// [R10] [R11] [R12] [R13]
			wire [3:0] mode_oh = {~sel_nz & tm, sel_nz & tm,
				sel_nz & ~tm, ~sel_nz & ~tm};
			wire [2:0] csel = c1_q[`ICST_C1_CSEL_HI:`ICST_C1_CSEL_LO];
			wire [1:0] emode = c1_q[`ICST_C1_MODE_HI:`ICST_C1_MODE_LO];
			// Codes above twenty select nothing
			// A held source level clears every cycle, so sources pulse
			wire sevt = sel_nz & (sel <= NSYNC) &
				sync_event_in[sel - 5'h01]; // [R15]
			wire rise = capture_input_pin_in[i] & ~pin_q;
			wire fall = ~capture_input_pin_in[i] & pin_q;
			wire wr_here = wr_chan & (wr_ch == IDX);
			wire pop = rd_acc & rd_chan & (rd_ch == IDX) &
				(rd_reg == `ICST_OFS_BUF);
			wire [`ICST_CNT_BITS-1:0] cnt_lvl;
			wire full;
			wire [CW-1:0] head;

			always @*
			begin
				case (mode_oh)
				M_FREE: run = 1'b1; // [R5]
				M_SYNC: run = 1'b1; // [R7]
				M_TRIG: run = c2_q[`ICST_C2_TSTAT]; // [R9]
				M_SWT: run = c2_q[`ICST_C2_TSTAT]; // [R14]
				default: run = 1'b0;
				endcase
			end

			assign own_run[i] = run;
			assign own_ok[i] = (csel < NCLK);
			assign own_tick[i] = own_ok[i] & clk_src_tick_in[csel]; // [R4]
			assign own_clr[i] = (mode_oh == M_SYNC) & sevt; // [R8]
			assign own_edge[i] = (emode == `ICST_EDGE_RISE) & rise |
				(emode == `ICST_EDGE_FALL) & fall |
				(emode == `ICST_EDGE_BOTH) & (rise | fall);

			// Upper half follows the lower channel's timing and events
			if (i % 2 == 1)
			begin : g_casc
				wire casc = c1_q[`ICST_C1_CASC];
				assign tick_eff[i] = casc ? carry_w[i-1] : own_tick[i]; // [R2]
				assign clr_eff[i] = casc ? clr_eff[i-1] : own_clr[i];
				assign run_eff[i] = casc ? run_eff[i-1] : own_run[i];
				assign push_w[i] = casc ? push_w[i-1] :
					own_edge[i] & own_ok[i] & own_run[i];
			end
			else
			begin : g_solo
				assign tick_eff[i] = own_tick[i];
				assign clr_eff[i] = own_clr[i];
				assign run_eff[i] = own_run[i];
				// Capture only with a valid clock and a running counter
				assign push_w[i] = own_edge[i] & own_ok[i] & own_run[i]; // [R7]
			end

			assign carry_w[i] = run_eff[i] & tick_eff[i] & ~clr_eff[i] &
				(&cnt_q);
			assign ovf_w[i] = push_w[i] & full & ~pop; // [R16]

			always @(posedge clk_in)
			begin
				if (sys_rst_in)
				begin
					c1_q <= `ICST_C1_RST;
					c2_q <= `ICST_C2_RST;
					cnt_q <= {CW{1'b0}};
					pin_q <= 1'b0;
				end
				else
				begin
					pin_q <= capture_input_pin_in[i];
					if (wr_here & (wr_reg == `ICST_OFS_CON1))
						c1_q <= hwdata_in[`ICST_C1_W-1:0];
					if (wr_here & (wr_reg == `ICST_OFS_CON2))
						c2_q <= hwdata_in[`ICST_C2_W-1:0];
					// Set wins over a software write in the same cycle
					if ((mode_oh == M_TRIG) & sevt)
						c2_q[`ICST_C2_TSTAT] <= 1'b1; // [R9]
					if (clr_eff[i])
						cnt_q <= {CW{1'b0}}; // [R8]
					else if (run_eff[i] & tick_eff[i])
						cnt_q <= cnt_q + 1'b1; // [R5]
				end
			end

			icst_fifo #(
				.W(CW),
				.D(FD),
				.PW(2),
				.CW(`ICST_CNT_BITS)
			) u_fifo ( // [R3]
				.clk_in(clk_in),
				.sys_rst_in(sys_rst_in),
				.push_in(push_w[i]),
				.pop_in(pop),
				.data_in(cnt_q), // [R6]
				.data_out(head),
				.count_out(cnt_lvl),
				.full_out(full)
			);

			assign c1_all[i*16 +: 16] = {7'h00, c1_q};
			assign c2_all[i*16 +: 16] = {8'h00, c2_q};
			assign data_all[i*16 +: 16] =
				(cnt_lvl == {`ICST_CNT_BITS{1'b0}}) ? 16'h0000 : head;
			assign st_all[i*16 +: 16] = {7'h00, run_eff[i], 5'h00, cnt_lvl};
		end
	endgenerate

	// ***********************************************
	// Interrupt status and mask
	// ***********************************************
	wire [`ICST_IRQ_W-1:0] ev_set = {ovf_w, push_w};
	wire [`ICST_IRQ_W-1:0] w1c = wr_irq_stat ?
		hwdata_in[`ICST_IRQ_W-1:0] : `ICST_IRQ_RST;
	// New events win over a clear in the same cycle
	wire [`ICST_IRQ_W-1:0] stat_d = (stat_q & ~w1c) | ev_set; // [R16]
	wire [`ICST_IRQ_W-1:0] mask_d = wr_irq_mask ?
		hwdata_in[`ICST_IRQ_W-1:0] : mask_q;

	always @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			stat_q <= `ICST_IRQ_RST;
			mask_q <= `ICST_IRQ_RST;
			irq_out <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_out <= |(stat_d & mask_d); // [R1]
		end
	end

endmodule // icst_top

`default_nettype wire

// >>> verif/icst_asserts.sv
// Checker on the capture block's bus and interrupt ports.
// Assumes it is bound to icst_top; one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none

module icst_chk #(
	parameter NCH = 5
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic [NCH-1:0] capture_input_pin_in,
	input wire logic irq_out
);
	// ****************
	// Decode
	// ****************
	wire logic take = hsel_in & hready_in & htrans_in[1];
	wire logic rd = take & ~hwrite_in;
	wire logic wr = take & hwrite_in;
	wire logic unm = haddr_in[31:8] != 24'h0 ||
		haddr_in[7:4] inside {4'h5, 4'h6, 4'h7};
	wire logic chn = !unm && !haddr_in[7];
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// ****************
	// Properties
	// ****************
	a_ready_high: assert property (hreadyout_out)
		else $error("hreadyout dropped");
	a_resp_okay: assert property (!hresp_out)
		else $error("hresp not okay");
	a_reset_values: assert property ($fell(sys_rst_in) |->
		!irq_out && hrdata_out == 32'h0) else $error("bad reset state");
	a_rdata_hold: assert property (!$past(rd) |-> $stable(hrdata_out))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (rd && unm |=> hrdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_stat_fields: assert property (
		rd && chn && haddr_in[3:0] == 4'hC |=> hrdata_out[31:9] == 23'h0
		&& hrdata_out[7:3] == 5'h0 && hrdata_out[2:0] <= 3'h4)
		else $error("fifo count out of range");
	a_buf_width: assert property (
		rd && chn && haddr_in[3:0] == 4'h8 |=> hrdata_out[31:16] == 16'h0)
		else $error("capture wider than counter");
	// Interrupt moves only on a pin change or a register write
	a_irq_rise: assert property ($rose(irq_out) |->
		$past(capture_input_pin_in) != $past(capture_input_pin_in, 2)
		|| $past(wr, 2) || $past(wr, 3)) else $error("irq rose unprompted");
	a_irq_fall: assert property ($fell(irq_out) |->
		$past(wr, 2) || $past(wr, 3)) else $error("irq fell unprompted");
endmodule // icst_chk

`default_nettype wire

// >>> verif/icst_pulse_src.sv
// Model of the pulse source and internal sync modules.
// Assumes commands arrive just after a rising edge of clk_in.
`timescale 1ns/100ps
`default_nettype none

module icst_pulse_src (
	input wire logic clk_in,
	output logic [4:0] pin_out,
	output logic [19:0] sync_out,
	output logic [5:0] tick_out
);
	initial
	begin
		pin_out = 5'h00;
		sync_out = 20'h00000;
		tick_out = 6'h3F;
	end
	task set_tick(input logic [5:0] v);
		tick_out <= v;
	endtask
	// Rising edges exactly gap cycles apart, so captures differ by gap
	task pulses(input logic [4:0] m, input int n, input int gap);
		repeat (n)
		begin
			pin_out <= m;
			repeat (gap / 2) @(posedge clk_in);
			pin_out <= 5'h00;
			repeat (gap - gap / 2) @(posedge clk_in);
		end
	endtask
	// One cycle only: a held level would clear the counter every cycle
	task sync_ev(input int b);
		sync_out[b] <= 1'b1;
		@(posedge clk_in);
		sync_out <= 20'h00000;
	endtask
endmodule // icst_pulse_src

`default_nettype wire

// >>> verif/icst_tb.sv
// Self-checking bench: AHB-Lite master tasks and capture scenarios.
// Assumes icst_top with zero-wait-state slave and the pulse model.
`timescale 1ns/100ps
`default_nettype none
`include "icst_defines.vh"

module testbench;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd_v;
	logic [31:0] v0;
	logic [31:0] v1;
	logic [31:0] rst_regs [5] = '{32'h0, 32'h4, 32'hC, 32'h80, 32'h84};
	// Free-running after reset, so the run bit of the status reads one
	logic [31:0] rst_exp [5] = '{32'h0, 32'h0, 32'h100, 32'h0, 32'h0};
	wire logic [31:0] hrdata;
	wire logic hready;
	wire logic hresp;
	wire logic irq;
	wire logic [4:0] pin;
	wire logic [19:0] sync;
	wire logic [5:0] tick;
	int n_mismatch = 0;
	int checked = 0;

	always #12.5 clk_in = ~clk_in;

	icst_top DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.capture_input_pin_in(pin), .sync_event_in(sync),
		.clk_src_tick_in(tick), .irq_out(irq));
	icst_pulse_src src (.clk_in(clk_in), .pin_out(pin), .sync_out(sync),
		.tick_out(tick));

	// ****************
	// Tasks
	// ****************
	task end_of_test;
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task wait_rdy;
		int i;
		i = 0;
		do
		begin
			@(posedge clk_in);
			i++;
		end
		while (hready !== 1'b1 && i < 64);
		if (hready !== 1'b1)
		begin
			n_mismatch++;
			end_of_test;
		end
	endtask
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd_v = hrdata;
	endtask
	task rdc(input string nm, input logic [31:0] a, m, e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd_v & m);
	endtask
	task gaps(input logic [31:0] a, input int n, input logic [15:0] g);
		logic [15:0] prev;
		xfer(1'b0, a, 32'h0);
		prev = rd_v[15:0];
		repeat (n - 1)
		begin
			xfer(1'b0, a, 32'h0);
			chk("capture gap", {16'h0, g}, {16'h0, rd_v[15:0] - prev});
			prev = rd_v[15:0];
		end
	endtask
	function logic [31:0] adr(input int c, input logic [3:0] o);
		return 32'h10 * c + {28'h0, o};
	endfunction

	// ****************
	// Scenarios
	// ****************
	initial
	begin
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		foreach (rst_regs[i])
			rdc("reset", rst_regs[i], 32'hFFFF, rst_exp[i]);
		xfer(1'b1, adr(0, `ICST_OFS_CON1), 32'h1);
		src.pulses(5'h01, 4, 8);
		repeat (5) @(posedge clk_in);
		src.pulses(5'h01, 1, 8);
		rdc("fifo count", adr(0, `ICST_OFS_STAT), 32'h7, 32'h4);
		rdc("irq status", 32'h80, 32'h3FF, 32'h21);
		chk("irq masked", 32'h0, {31'h0, irq});
		xfer(1'b1, 32'h84, 32'h21);
		repeat (2) @(posedge clk_in);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		gaps(adr(0, `ICST_OFS_BUF), 4, 16'h8);
		rdc("empty read", adr(0, `ICST_OFS_BUF), 32'hFFFFFFFF, 32'h0);
		xfer(1'b1, 32'h80, 32'h21);
		repeat (2) @(posedge clk_in);
		chk("irq cleared", 32'h0, {31'h0, irq});
		src.set_tick(6'h08);
		xfer(1'b1, adr(1, `ICST_OFS_CON1), 32'hD);
		xfer(1'b1, adr(2, `ICST_OFS_CON1), 32'h1);
		src.pulses(5'h06, 2, 8);
		gaps(adr(1, `ICST_OFS_BUF), 2, 16'h8);
		gaps(adr(2, `ICST_OFS_BUF), 2, 16'h0);
		src.set_tick(6'h3F);
		for (int n = 1; n <= 20; n++)
		begin
			xfer(1'b1, adr(0, `ICST_OFS_CON2), n);
			src.sync_ev(n - 1);
			repeat (6) @(posedge clk_in);
			src.pulses(5'h01, 1, 8);
			rdc("sync clear", adr(0, `ICST_OFS_BUF), 32'hFFFF, 32'h6);
		end
		xfer(1'b1, adr(2, `ICST_OFS_CON2), 32'h83);
		src.pulses(5'h04, 1, 8);
		rdc("trig hold", adr(2, `ICST_OFS_STAT), 32'h7, 32'h0);
		src.sync_ev(2);
		rdc("trig seen", adr(2, `ICST_OFS_CON2), 32'hFF, 32'hC3);
		src.pulses(5'h04, 3, 8);
		gaps(adr(2, `ICST_OFS_BUF), 3, 16'h8);
		xfer(1'b1, adr(3, `ICST_OFS_CON1), 32'h1);
		xfer(1'b1, adr(3, `ICST_OFS_CON2), 32'h80);
		src.pulses(5'h08, 1, 8);
		rdc("sw hold", adr(3, `ICST_OFS_STAT), 32'h7, 32'h0);
		xfer(1'b1, adr(3, `ICST_OFS_CON2), 32'hC0);
		src.pulses(5'h08, 3, 8);
		gaps(adr(3, `ICST_OFS_BUF), 3, 16'h8);
		xfer(1'b1, adr(0, `ICST_OFS_CON2), 32'h0);
		xfer(1'b1, adr(1, `ICST_OFS_CON1), 32'h100);
		src.pulses(5'h01, 2, 8);
		rdc("pair count", adr(1, `ICST_OFS_STAT), 32'h7, 32'h2);
		xfer(1'b0, adr(0, `ICST_OFS_BUF), 32'h0);
		v0[15:0] = rd_v[15:0];
		xfer(1'b0, adr(1, `ICST_OFS_BUF), 32'h0);
		v0[31:16] = rd_v[15:0];
		xfer(1'b0, adr(0, `ICST_OFS_BUF), 32'h0);
		v1[15:0] = rd_v[15:0];
		xfer(1'b0, adr(1, `ICST_OFS_BUF), 32'h0);
		v1[31:16] = rd_v[15:0];
		chk("pair gap", 32'h8, v1 - v0);
		xfer(1'b1, adr(4, `ICST_OFS_CON1), 32'h3);
		src.pulses(5'h10, 2, 8);
		gaps(adr(4, `ICST_OFS_BUF), 4, 16'h4);
		xfer(1'b1, adr(4, `ICST_OFS_CON1), 32'h2);
		src.pulses(5'h10, 2, 8);
		gaps(adr(4, `ICST_OFS_BUF), 2, 16'h8);
		xfer(1'b1, adr(4, `ICST_OFS_CON1), 32'h19);
		src.pulses(5'h10, 1, 8);
		rdc("no clock", adr(4, `ICST_OFS_STAT), 32'h7, 32'h0);
		xfer(1'b1, 32'h50, 32'hFFFFFFFF);
		rdc("unmapped", 32'h50, 32'hFFFFFFFF, 32'h0);
		rdc("unmapped", 32'h100, 32'hFFFFFFFF, 32'h0);
		end_of_test;
	end
endmodule // testbench

bind icst_top icst_chk #(.NCH(NCH)) u_chk (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
	.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
	.hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out), .capture_input_pin_in(capture_input_pin_in),
	.irq_out(irq_out));

`default_nettype wire
